// *** bsn_pkg.sv ***
// Package of the bus sensor node supervisor: constants, timing and carrier structs.
// Assumes a single 250 MHz clock and a synchronous active-low reset.
package bsn_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ            = 250;
  localparam int unsigned SW_CLOSE_MIN_US    = 100;
  localparam int unsigned SW_CLOSE_MAX_US    = 200;
  localparam int unsigned NON_IDLE_LIMIT_MS  = 100;
  localparam int unsigned ADC_MAX_US         = 27;
  // Target between min and max; min rounds up, max rounds down
  localparam int unsigned SW_CLOSE_MIN_CYC   = SW_CLOSE_MIN_US * CLK_MHZ;
  localparam int unsigned SW_CLOSE_MAX_CYC   = SW_CLOSE_MAX_US * CLK_MHZ;
  localparam int unsigned SW_CLOSE_CYC       = (SW_CLOSE_MIN_CYC + SW_CLOSE_MAX_CYC) / 2;
  localparam int unsigned NON_IDLE_CYC       = NON_IDLE_LIMIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned ADC_MAX_CYC        = ADC_MAX_US * CLK_MHZ;
  localparam int unsigned ADC_BITS           = 8;
  localparam int unsigned ADC_BIT_CYC        = ADC_MAX_CYC / (ADC_BITS + 2);

  // ----------------------------------------------------------------
  // Data values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADC_ERROR_CODE = 8'h00;
  localparam logic [7:0] ADC_ZERO_SUBST = 8'h01;
  localparam logic [3:0] ADDR_RESET     = 4'h0;
  localparam logic [1:0] GPIO_CH_MAX    = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BSN_GP_ANALOG = 2'b00,
    BSN_GP_DIN    = 2'b01,
    BSN_GP_DOUT   = 2'b10
  } bsn_gp_mode_t;

  typedef struct packed {
    logic        init_fwd;      // Initialization seen on upstream pin
    logic        init_rev;      // Initialization seen on downstream pin
    logic        nv_write;      // Nonvolatile access command, write
    logic        status_read;   // Status query command
    logic        gpio_cfg;      // General-purpose line configuration
    logic        adc_query;     // Analog value query
    logic [3:0]  addr;
    logic [1:0]  channel;
    logic [7:0]  cfg_data;      // Two bits per line
    logic        out_level;
  } bsn_cmd_t;

  typedef struct packed {
    logic        adc_valid;     // One-cycle pulse with the result
    logic [7:0]  adc_value;
    logic        status_valid;  // One-cycle pulse with the status
    logic        uv_status;
    logic        nv_refused;    // One-cycle pulse on a refused write
  } bsn_rsp_t;

endpackage

// *** bsn_nv_store.sv ***
// One-time programmable address store with a hardware write lock.
// Assumes writes arrive only from the supervisor's access command path.
module bsn_nv_store (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Access
  input  wire logic       wr_req,
  input  wire logic [3:0] wr_addr,
  // State
  output logic      [3:0] rd_addr,
  output logic            locked,
  output logic            refused
);

  logic [3:0] next_rd_addr;
  logic       next_locked;
  logic       next_refused;

  always_comb begin
    next_rd_addr = rd_addr;
    next_locked  = locked;
    next_refused = 1'b0;
    if (wr_req) begin
      if (locked) begin
        next_refused = 1'b1;
      end else begin
        next_rd_addr = wr_addr;
        next_locked  = 1'b1;
      end
    end
  end

  // Contents survive logic reset as nonvolatile storage would
  always_ff @(posedge ref_clk) begin
    rd_addr <= next_rd_addr;
    locked  <= next_locked;
    if (!resetn) begin
      refused <= 1'b0;
    end else begin
      refused <= next_refused;
    end
  end

endmodule

// *** bsn_supervisor.sv ***
// Supervisor of a bus-powered sensor node: switch timing, timeout, undervoltage,
// conversion sequencing, line configuration and reply current sink.
// Assumes decoded commands arrive as one-cycle pulses and that resetn follows power-on reset.
//
// Behaviour
// - Close bus switch 100 to 200 us after init
// - Reset node after too long non-idle bus
// - Conversion finishes within 27 us
// - Address store written once, via access command
// - Latch undervoltage indication as pending status
// - Report status on query, then clear it
// - Undervoltage at conversion end returns zero
// - Hold logic in reset below power-on threshold
// - Accept forward init on upstream pin
// - Accept reverse init on downstream pin, only before the node is initialized
// - Configure four lines analog, input or output
// - Convert and reply only when queried
// - Reply bits by current sink, not voltage
// - Genuine zero conversion reported as one
module bsn_supervisor (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  // Power monitors
  input  wire logic                holding_capacitor_rail_ok,
  input  wire logic                regulated_sensor_supply_low,
  // Bus level detector
  input  wire logic                upstream_bus_pin_idle,
  input  wire logic                downstream_bus_pin_idle,
  input  wire logic                reply_bit,
  input  wire logic                reply_active,
  // Decoded commands
  input  wire bsn_pkg::bsn_cmd_t   cmd,
  // Converter comparator
  input  wire logic                adc_cmp_high,
  // General-purpose lines
  input  wire logic [3:0]          gp_in,
  output logic      [3:0]          gp_out,
  output logic      [3:0]          gp_oe_n,
  output logic      [3:0]          gp_analog_en,
  output logic                     high_drive_output,
  // Converter control
  output logic      [7:0]          adc_trial,
  output logic      [1:0]          adc_channel,
  // Bus outputs
  output logic                     bus_switch_closed,
  output logic                     current_sink_on,
  output logic                     node_reset_req,
  output logic      [3:0]          node_addr,
  output bsn_pkg::bsn_rsp_t        rsp
);

  // ----------------------------------------------------------------
  // Reset and timeout
  // ----------------------------------------------------------------
  logic        rst_n;
  logic [24:0] idle_cnt;
  logic [24:0] next_idle_cnt;
  logic        bus_idle;

  assign rst_n    = resetn & holding_capacitor_rail_ok & ~node_reset_req;
  assign bus_idle = upstream_bus_pin_idle & downstream_bus_pin_idle;

  always_comb begin
    next_idle_cnt = idle_cnt;
    if (bus_idle) begin
      next_idle_cnt = '0;
    end else if (idle_cnt < 25'(bsn_pkg::NON_IDLE_CYC)) begin
      next_idle_cnt = idle_cnt + 25'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn || !holding_capacitor_rail_ok) begin
      idle_cnt       <= '0;
      node_reset_req <= 1'b0;
    end else begin
      idle_cnt       <= node_reset_req ? '0 : next_idle_cnt;
      node_reset_req <= (idle_cnt >= 25'(bsn_pkg::NON_IDLE_CYC)) && !node_reset_req;
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile address store
  // ----------------------------------------------------------------
  logic [3:0] nv_addr;
  logic       nv_locked;
  logic       nv_refused;

  bsn_nv_store u_nv (
    .ref_clk (ref_clk),
    .resetn  (rst_n),
    .wr_req  (cmd.nv_write),
    .wr_addr (cmd.addr),
    .rd_addr (nv_addr),
    .locked  (nv_locked),
    .refused (nv_refused)
  );

  // ----------------------------------------------------------------
  // Initialization and bus switch
  // ----------------------------------------------------------------
  logic        inited;
  logic        next_inited;
  logic [15:0] sw_cnt;
  logic [15:0] next_sw_cnt;
  logic        sw_run;
  logic        next_sw_run;
  logic        next_switch;
  logic [3:0]  next_addr;
  logic        init_hit;

  // Reverse init only acts before the node is initialized
  assign init_hit = cmd.init_fwd | (cmd.init_rev & ~inited);

  always_comb begin
    next_inited = inited;
    next_sw_cnt = sw_cnt;
    next_sw_run = sw_run;
    next_switch = bus_switch_closed;
    next_addr   = node_addr;
    if (init_hit) begin
      next_inited = 1'b1;
      next_addr   = nv_locked ? nv_addr : cmd.addr;
      next_sw_run = 1'b1;
      next_sw_cnt = '0;
    end else if (sw_run) begin
      if (sw_cnt == 16'(bsn_pkg::SW_CLOSE_CYC - 1)) begin
        next_switch = 1'b1;
        next_sw_run = 1'b0;
      end else begin
        next_sw_cnt = sw_cnt + 16'd1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      inited            <= 1'b0;
      sw_cnt            <= '0;
      sw_run            <= 1'b0;
      bus_switch_closed <= 1'b0;
      node_addr         <= bsn_pkg::ADDR_RESET;
    end else begin
      inited            <= next_inited;
      sw_cnt            <= next_sw_cnt;
      sw_run            <= next_sw_run;
      bus_switch_closed <= next_switch;
      node_addr         <= next_addr;
    end
  end

  // ----------------------------------------------------------------
  // Line configuration
  // ----------------------------------------------------------------
  logic [7:0] gp_mode;
  logic [7:0] next_gp_mode;
  logic [3:0] next_gp_out;
  logic       next_hd;

  function automatic logic is_mode(input logic [7:0] m, input int unsigned i, input bsn_pkg::bsn_gp_mode_t k);
    is_mode = (m[2*i +: 2] == k);
  endfunction

  always_comb begin
    next_gp_mode = gp_mode;
    next_gp_out  = gp_out;
    next_hd      = high_drive_output;
    if (cmd.gpio_cfg) begin
      next_gp_mode = cmd.cfg_data;
      next_gp_out[cmd.channel] = cmd.out_level;
      next_hd      = cmd.out_level & (cmd.channel == bsn_pkg::GPIO_CH_MAX) & cmd.addr[0];
    end
    for (int i = 0; i < 4; i++) begin
      gp_oe_n[i]      = ~is_mode(gp_mode, i, bsn_pkg::BSN_GP_DOUT);
      gp_analog_en[i] = is_mode(gp_mode, i, bsn_pkg::BSN_GP_ANALOG);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gp_mode           <= {4{bsn_pkg::BSN_GP_DIN}};
      gp_out            <= '0;
      high_drive_output <= 1'b0;
    end else begin
      gp_mode           <= next_gp_mode;
      gp_out            <= next_gp_out;
      high_drive_output <= next_hd;
    end
  end

  // ----------------------------------------------------------------
  // Undervoltage status and conversion
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BSN_ADC_IDLE = 2'b00,
    BSN_ADC_CONV = 2'b01,
    BSN_ADC_DONE = 2'b10
  } bsn_adc_state_t;

  bsn_adc_state_t    adc_st;
  bsn_adc_state_t    next_adc_st;
  logic              uv_pending;
  logic              next_uv_pending;
  logic [2:0]        bit_idx;
  logic [2:0]        next_bit_idx;
  logic [9:0]        bit_cnt;
  logic [9:0]        next_bit_cnt;
  logic [7:0]        next_trial;
  logic [1:0]        next_channel;
  bsn_pkg::bsn_rsp_t next_rsp;

  always_comb begin
    next_adc_st     = adc_st;
    next_bit_idx    = bit_idx;
    next_bit_cnt    = bit_cnt;
    next_trial      = adc_trial;
    next_channel    = adc_channel;
    next_rsp        = '0;
    next_uv_pending = uv_pending;
    if (cmd.status_read) begin
      next_rsp.status_valid = 1'b1;
      next_rsp.uv_status    = uv_pending;
      next_uv_pending       = 1'b0;
    end
    if (regulated_sensor_supply_low) begin
      next_uv_pending = 1'b1;
    end
    next_rsp.nv_refused = nv_refused;
    case (adc_st)
      BSN_ADC_IDLE: begin
        if (cmd.adc_query) begin
          next_adc_st  = BSN_ADC_CONV;
          next_channel = cmd.channel;
          next_trial   = 8'h80;
          next_bit_idx = 3'd7;
          next_bit_cnt = '0;
        end
      end
      BSN_ADC_CONV: begin
        if (bit_cnt == 10'(bsn_pkg::ADC_BIT_CYC - 1)) begin
          next_bit_cnt = '0;
          next_trial[bit_idx] = adc_cmp_high;
          if (bit_idx == 3'd0) begin
            next_adc_st = BSN_ADC_DONE;
          end else begin
            next_trial[bit_idx - 3'd1] = 1'b1;
            next_bit_idx = bit_idx - 3'd1;
          end
        end else begin
          next_bit_cnt = bit_cnt + 10'd1;
        end
      end
      BSN_ADC_DONE: begin
        next_adc_st        = BSN_ADC_IDLE;
        next_rsp.adc_valid = 1'b1;
        if (regulated_sensor_supply_low) begin
          next_rsp.adc_value = bsn_pkg::ADC_ERROR_CODE;
        end else if (adc_trial == bsn_pkg::ADC_ERROR_CODE) begin
          next_rsp.adc_value = bsn_pkg::ADC_ZERO_SUBST;
        end else begin
          next_rsp.adc_value = adc_trial;
        end
      end
      default: begin
        next_adc_st = BSN_ADC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      adc_st      <= BSN_ADC_IDLE;
      uv_pending  <= 1'b0;
      bit_idx     <= '0;
      bit_cnt     <= '0;
      adc_trial   <= '0;
      adc_channel <= '0;
      rsp         <= '0;
    end else begin
      adc_st      <= next_adc_st;
      uv_pending  <= next_uv_pending;
      bit_idx     <= next_bit_idx;
      bit_cnt     <= next_bit_cnt;
      adc_trial   <= next_trial;
      adc_channel <= next_channel;
      rsp         <= next_rsp;
    end
  end

  // ----------------------------------------------------------------
  // Reply current sink
  // ----------------------------------------------------------------
  logic next_sink;

  // Sink is off whenever the bus is idle; slew limiting is analog
  assign next_sink = reply_active & reply_bit & ~bus_idle;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      current_sink_on <= 1'b0;
    end else begin
      current_sink_on <= next_sink;
    end
  end

endmodule

// *** bsn_supervisor_sva.sv ***
// Checker of the sensor node supervisor, bound to its top module.
// Assumes one clock; resetn and the rail monitor both reset the logic.
module bsn_supervisor_chk (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              resetn,
  // Inputs
  input wire logic              holding_capacitor_rail_ok,
  input wire logic              regulated_sensor_supply_low,
  input wire logic              upstream_bus_pin_idle,
  input wire logic              downstream_bus_pin_idle,
  input wire logic              reply_bit,
  input wire logic              reply_active,
  input wire bsn_pkg::bsn_cmd_t cmd,
  // Outputs
  input wire logic              bus_switch_closed,
  input wire logic              current_sink_on,
  input wire logic              node_reset_req,
  input wire logic [3:0]        gp_analog_en,
  input wire bsn_pkg::bsn_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  localparam int ADC_LIM = bsn_pkg::ADC_MAX_CYC;
  localparam logic [24:0] NI_LO = 25'(bsn_pkg::NON_IDLE_CYC - 2);
  localparam logic [24:0] NI_HI = 25'(bsn_pkg::NON_IDLE_CYC + 3);
  logic        clr, sw_run, adc_busy, uv_pend, next_sw_run, next_adc_busy, next_uv_pend;
  logic [15:0] sw_cnt, next_sw_cnt;
  logic [24:0] ni_cnt, next_ni_cnt;
  logic [12:0] adc_cnt, next_adc_cnt;

  function automatic logic [3:0] an_mask(input logic [7:0] c);
    for (int i = 0; i < 4; i++) an_mask[i] = (c[2*i+:2] == 2'b00);
  endfunction

  // ----------------------------------------------------------------
  // Helper state: switch delay, busy conversion, pending status, non-idle time
  // ----------------------------------------------------------------
  assign clr = !resetn || !holding_capacitor_rail_ok || node_reset_req;
  always_comb begin
    next_sw_run   = (sw_run || cmd.init_fwd || cmd.init_rev) && !bus_switch_closed;
    next_sw_cnt   = next_sw_run ? sw_cnt + 16'h0001 : 16'h0000;
    next_adc_busy = (adc_busy || cmd.adc_query) && !rsp.adc_valid;
    next_uv_pend  = regulated_sensor_supply_low || (uv_pend && !cmd.status_read);
    next_ni_cnt   = (upstream_bus_pin_idle && downstream_bus_pin_idle) ? 25'h000_0000 :
                    (ni_cnt == '1) ? ni_cnt : ni_cnt + 25'h000_0001;
    next_adc_cnt  = next_adc_busy ? adc_cnt + 13'h0001 : 13'h0000;
  end
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      sw_run   <= 1'b0;
      sw_cnt   <= 16'h0000;
      adc_busy <= 1'b0;
      uv_pend  <= 1'b0;
      ni_cnt   <= 25'h000_0000;
      adc_cnt  <= 13'h0000;
    end else begin
      sw_run   <= next_sw_run;
      sw_cnt   <= next_sw_cnt;
      adc_busy <= next_adc_busy;
      uv_pend  <= next_uv_pend;
      ni_cnt   <= next_ni_cnt;
      adc_cnt  <= next_adc_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_switch_early: assert property ($rose(bus_switch_closed) |-> sw_cnt >= bsn_pkg::SW_CLOSE_MIN_CYC)
    else $error("bus switch closed too soon after init");
  chk_switch_late: assert property (sw_run |-> sw_cnt <= bsn_pkg::SW_CLOSE_MAX_CYC + 2)
    else $error("bus switch closed too late after init");
  chk_timeout_early: assert property (node_reset_req |-> ni_cnt >= NI_LO)
    else $error("node reset before non-idle limit");
  chk_timeout_late: assert property (ni_cnt <= NI_HI)
    else $error("no node reset after non-idle limit");
  chk_status_answer: assert property (cmd.status_read |=> rsp.status_valid)
    else $error("status query not answered");
  chk_uv_held: assert property (cmd.status_read && uv_pend |=> rsp.uv_status)
    else $error("pending undervoltage not reported");
  chk_uv_cleared: assert property (cmd.status_read && !uv_pend && !regulated_sensor_supply_low |=> !rsp.uv_status)
    else $error("undervoltage reported after clear");
  chk_adc_answer: assert property (adc_busy |-> adc_cnt <= ADC_LIM)
    else $error("conversion not finished in time");
  chk_adc_unasked: assert property (rsp.adc_valid |-> adc_busy)
    else $error("conversion result without query");
  chk_adc_uv_zero: assert property (rsp.adc_valid && $past(regulated_sensor_supply_low) |-> rsp.adc_value == 8'h00)
    else $error("conversion under low supply not zero");
  chk_adc_nonzero: assert property (rsp.adc_valid && !$past(regulated_sensor_supply_low) |-> rsp.adc_value != 8'h00)
    else $error("zero conversion value with good supply");
  chk_sink_on: assert property (reply_active && reply_bit && !upstream_bus_pin_idle && !downstream_bus_pin_idle
    |=> current_sink_on) else $error("current sink off for a one bit");
  chk_sink_idle: assert property (upstream_bus_pin_idle && downstream_bus_pin_idle |=> !current_sink_on)
    else $error("current sink on while bus idle");
  chk_rail_reset: assert property (!holding_capacitor_rail_ok |=> !bus_switch_closed && !current_sink_on)
    else $error("outputs active below power-on threshold");
  chk_gpio_modes: assert property (cmd.gpio_cfg |=> gp_analog_en == an_mask($past(cmd.cfg_data)))
    else $error("line analog enables differ from config");

  cover property ($rose(bus_switch_closed));
  cover property (rsp.adc_valid && rsp.adc_value == 8'h01);
  cover property (rsp.status_valid && rsp.uv_status);
endmodule

bind bsn_supervisor bsn_supervisor_chk i_chk (
  .ref_clk, .resetn, .holding_capacitor_rail_ok, .regulated_sensor_supply_low, .upstream_bus_pin_idle,
  .downstream_bus_pin_idle, .reply_bit, .reply_active, .cmd, .bus_switch_closed, .current_sink_on,
  .node_reset_req, .gp_analog_en, .rsp
);

// *** bsn_ccu_model.sv ***
// Central controller model: issues decoded commands and drives bus levels.
// Assumes the node takes a command on the rising edge where its pulse is high.
module bsn_ccu_model (
  // Clock
  input  wire logic        ref_clk,
  // Commands and bus levels
  output bsn_pkg::bsn_cmd_t cmd,
  output logic              upstream_bus_pin_idle,
  output logic              downstream_bus_pin_idle,
  output logic              reply_bit,
  output logic              reply_active
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cmd = '0;
    {upstream_bus_pin_idle, downstream_bus_pin_idle, reply_active, reply_bit} = 4'hC;
  end

  // Every exchange and every line setting starts here, one pulse per command
  task automatic send(input bsn_pkg::bsn_cmd_t c);
    @(posedge ref_clk);
    #1 cmd = c;
    @(posedge ref_clk);
    #1 cmd = '0;
  endtask

  task automatic bus(input logic [3:0] lv);
    @(posedge ref_clk);
    #1 {upstream_bus_pin_idle, downstream_bus_pin_idle, reply_active, reply_bit} = lv;
  endtask
endmodule

// *** testbench.sv ***
// Self-checking bench of the sensor node supervisor.
// Assumes the package, design, checker and controller model are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [5:0] FWD = 6'h20, REV = 6'h10, NVW = 6'h08, STS = 6'h04, GPC = 6'h02, ADQ = 6'h01;
  logic              ref_clk = 1'b0;
  logic              resetn = 1'b0;
  logic              rail_ok = 1'b1;
  logic              uv_low = 1'b0;
  logic [7:0]        level = 8'h00;
  logic              up_idle, dn_idle, rbit, ract, cmp, closed, sink, nrst, hd;
  logic [1:0]        ach;
  logic [7:0]        trial;
  logic [3:0]        gp_out, gp_oe_n, gp_an, addr;
  bsn_pkg::bsn_cmd_t cmd;
  bsn_pkg::bsn_rsp_t rsp;
  int                n_mismatch = 0;
  int                n_checks = 0;
  int                cyc = 0;

  always #2 ref_clk = ~ref_clk;
  // Comparator of the converter: sensor level against trial code
  assign cmp = (level >= trial);

  bsn_supervisor i_dut (
    .ref_clk, .resetn, .holding_capacitor_rail_ok(rail_ok), .regulated_sensor_supply_low(uv_low),
    .upstream_bus_pin_idle(up_idle), .downstream_bus_pin_idle(dn_idle), .reply_bit(rbit),
    .reply_active(ract), .cmd, .adc_cmp_high(cmp), .gp_in(4'h0), .gp_out, .gp_oe_n,
    .gp_analog_en(gp_an), .high_drive_output(hd), .adc_trial(trial), .adc_channel(ach),
    .bus_switch_closed(closed), .current_sink_on(sink), .node_reset_req(nrst), .node_addr(addr), .rsp
  );
  bsn_ccu_model i_ccu (
    .ref_clk, .cmd, .upstream_bus_pin_idle(up_idle), .downstream_bus_pin_idle(dn_idle),
    .reply_bit(rbit), .reply_active(ract)
  );

  function automatic bsn_pkg::bsn_cmd_t mk(input logic [5:0] op, input logic [3:0] a, input logic [7:0] d);
    mk = '0;
    {mk.init_fwd, mk.init_rev, mk.nv_write, mk.status_read, mk.gpio_cfg, mk.adc_query} = op;
    mk.addr = a;
    mk.channel = a[1:0];
    mk.cfg_data = d;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_nv_lock();
    i_ccu.send(mk(NVW, 4'h5, 8'h00));
    i_ccu.send(mk(NVW, 4'hA, 8'h00));
    @(posedge ref_clk);
    #1 check("second write refused", rsp.nv_refused, 1);
  endtask

  task automatic t_gpio(input logic [3:0] a, input logic [7:0] d, input logic [3:0] an, input logic [3:0] oe_n,
                        input logic [3:0] go, input logic hd_exp);
    bsn_pkg::bsn_cmd_t c;
    c = mk(GPC, a, d);
    c.out_level = 1'b1;
    i_ccu.send(c);
    @(posedge ref_clk);
    #1 check("analog enables", gp_an, an);
    check("output enables", gp_oe_n, oe_n);
    check("output levels", gp_out, go);
    check("high drive output", hd, hd_exp);
  endtask

  task automatic t_sink(input logic [3:0] lv, input logic exp);
    i_ccu.bus(lv);
    @(posedge ref_clk);
    #1 check("current sink", sink, exp);
  endtask

  task automatic t_status();
    uv_low = 1'b1;
    @(posedge ref_clk);
    #1 uv_low = 1'b0;
    for (int i = 1; i >= 0; i--) begin
      i_ccu.send(mk(STS, 4'h0, 8'h00));
      check("status valid", rsp.status_valid, 1);
      check("undervoltage status", rsp.uv_status, i[0]);
    end
  endtask

  task automatic t_adc(input logic [7:0] lv, input logic uv, input logic [7:0] exp);
    int n;
    level = lv;
    uv_low = uv;
    i_ccu.send(mk(ADQ, 4'h2, 8'h00));
    n = 0;
    while (rsp.adc_valid !== 1'b1 && n < 7000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check("conversion in time", n <= bsn_pkg::ADC_MAX_CYC, 1);
    check("conversion value", rsp.adc_value, exp);
    check("conversion channel", ach, 2'd2);
    uv_low = 1'b0;
  endtask

  task automatic t_init(input logic [5:0] op);
    int n;
    i_ccu.send(mk(op, 4'h9, 8'h00));
    n = 0;
    while (closed !== 1'b1 && n < 60000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check("switch delay", n >= bsn_pkg::SW_CLOSE_MIN_CYC && n <= bsn_pkg::SW_CLOSE_MAX_CYC + 1, 1);
    check("locked address", addr, 4'h5);
    rail_ok = 1'b0;
    @(posedge ref_clk);
    #1 check("switch open in power-on reset", closed, 0);
    rail_ok = 1'b1;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 100000) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    #1 resetn = 1'b1;
    t_nv_lock();
    t_gpio(4'h2, 8'h24, 4'h9, 4'hB, 4'h4, 1'b0);
    t_gpio(4'h3, 8'hAA, 4'h0, 4'h0, 4'hC, 1'b1);
    t_sink(4'h3, 1'b1);
    t_sink(4'h2, 1'b0);
    t_sink(4'hF, 1'b0);
    t_sink(4'hC, 1'b0);
    t_status();
    t_adc(8'hA5, 1'b0, 8'hA5);
    t_adc(8'h00, 1'b0, 8'h01);
    t_adc(8'hA5, 1'b1, 8'h00);
    t_init(FWD);
    t_init(REV);
    final_report();
  end
endmodule
